// ===== hw/fpo_consts.svh
// offsets, field positions, reset values for the programmable flag offset block
`ifndef FPO_CONSTS_SVH
`define FPO_CONSTS_SVH

// ====================================================================
// register byte offsets
`define FPO_REG_STATUS 8'h00
`define FPO_REG_MASK 8'h04
`define FPO_REG_EMPTY_OFS 8'h08
`define FPO_REG_FULL_OFS 8'h0c
`define FPO_REG_SERIAL 8'h10
`define FPO_REG_CONFIG 8'h14

// ====================================================================
// field positions
`define FPO_ST_AE_BIT 0
`define FPO_ST_AF_BIT 1
`define FPO_CFG_SERIAL_BIT 0
`define FPO_CFG_SYNC_BIT 1
`define FPO_CFG_DEPTH_LSB 4
`define FPO_CFG_COUNT_LSB 8

// ====================================================================
// widths and reset values
`define FPO_OFS_W 16
`define FPO_CNT_W 17
`define FPO_SER_BITS 6'h20
`define FPO_DEPTH_LOG_BASE 9
`define FPO_MASK_RST 2'h0
`define FPO_OFS_RST 16'h007f

// ====================================================================
// default offsets
`define FPO_OFS_3 16'h0003
`define FPO_OFS_7 16'h0007
`define FPO_OFS_15 16'h000f
`define FPO_OFS_31 16'h001f
`define FPO_OFS_63 16'h003f
`define FPO_OFS_127 16'h007f
`define FPO_OFS_255 16'h00ff
`define FPO_OFS_511 16'h01ff
`define FPO_OFS_1023 16'h03ff
`define FPO_OFS_2047 16'h07ff
`define FPO_OFS_4095 16'h0fff
`define FPO_OFS_8191 16'h1fff
`define FPO_OFS_16383 16'h3fff

`endif

// ===== hw/fpo_pkg.sv
// types for the programmable flag offset block
package fpo_pkg;
    // depth group: 512 << depth_sel words
    typedef enum logic [2:0] {
        FPO_D512, FPO_D1K, FPO_D2K, FPO_D4K, FPO_D8K, FPO_D16K, FPO_D32K, FPO_D64K
    } fpo_depth_t;

    // settings caught during master reset
    typedef struct packed {
        logic serial_mode;
        logic sync_flags;
        fpo_depth_t depth;
    } fpo_cfg_t;

    // default offset select straps
    typedef struct packed {
        logic load;
        logic sel1;
        logic sel0;
    } fpo_strap_t;
endpackage

// ===== hw/fpo_default_offset.sv
// default flag offset decode from the straps and the depth group
`include "fpo_consts.svh"
module fpo_default_offset
    import fpo_pkg::*;
(
    // straps
    input wire fpo_strap_t strap,
    input wire fpo_depth_t depth,
    // decoded offset
    output logic [15:0] offset
);
    always_comb begin
        offset = `FPO_OFS_127;
        if (depth == FPO_D512 || depth == FPO_D1K) begin
            unique case (strap)
                3'b010: offset = `FPO_OFS_511;
                3'b001: offset = `FPO_OFS_255;
                3'b000: offset = `FPO_OFS_127;
                3'b011: offset = `FPO_OFS_63;
                3'b100: offset = `FPO_OFS_31;
                3'b110: offset = `FPO_OFS_15;
                3'b101: offset = `FPO_OFS_7;
                3'b111: offset = `FPO_OFS_3;
            endcase
        end else if (depth == FPO_D32K || depth == FPO_D64K) begin
            unique case (strap)
                3'b010: offset = `FPO_OFS_16383;
                3'b001: offset = `FPO_OFS_8191;
                3'b011: offset = `FPO_OFS_4095;
                3'b110: offset = `FPO_OFS_2047;
                3'b100: offset = `FPO_OFS_1023;
                3'b101: offset = `FPO_OFS_511;
                3'b111: offset = `FPO_OFS_255;
                3'b000: offset = `FPO_OFS_127;
            endcase
        end else begin
            unique case (strap)
                3'b100: offset = `FPO_OFS_1023;
                3'b010: offset = `FPO_OFS_511;
                3'b001: offset = `FPO_OFS_255;
                3'b000: offset = `FPO_OFS_127;
                3'b011: offset = `FPO_OFS_63;
                3'b110: offset = `FPO_OFS_31;
                3'b101: offset = `FPO_OFS_15;
                3'b111: offset = `FPO_OFS_7;
            endcase
        end
    end
endmodule // fpo_default_offset

// ===== hw/fpo_top.sv
// programmable almost-empty / almost-full offset and flag timing block
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`include "fpo_consts.svh"
module fpo_top
    import fpo_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // fifo resets and straps
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic offset_load_select,
    input wire logic default_offset_sel1,
    input wire logic default_offset_sel0,
    input wire logic flag_timing_select,
    input wire logic [2:0] depth_select,
    // write and read clock edge enables
    input wire logic wclk_rise,
    input wire logic write_en,
    input wire logic rclk_rise,
    input wire logic read_en,
    input wire logic offset_read,
    // flags and data
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic [71:0] parallel_data_out,
    output logic irq
);
    // ================================================================
    // settings and count helpers
    function automatic logic [16:0] depth_words(input fpo_depth_t d);
        depth_words = 17'(17'h0_0001 << (`FPO_DEPTH_LOG_BASE + 32'(d)));
    endfunction

    function automatic logic ae_cond(input logic [16:0] cnt, input logic [15:0] n);
        ae_cond = cnt <= {1'b0, n};
    endfunction

    function automatic logic af_cond(input logic [16:0] cnt, input logic [15:0] m,
                                     input fpo_depth_t d);
        af_cond = (depth_words(d) - cnt) <= {1'b0, m};
    endfunction

    fpo_cfg_t cfg_q;
    fpo_strap_t strap;
    logic [15:0] default_ofs;
    logic [15:0] empty_ofs_q;
    logic [15:0] full_ofs_q;
    logic [31:0] ser_shift_q;
    logic [5:0] ser_cnt_q;
    logic [16:0] count_q;
    logic [16:0] count_d;
    logic do_wr;
    logic do_rd;
    logic rb_sel_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic dp_wr_q;
    logic [7:0] dp_addr_q;
    logic ae_next;
    logic af_next;
    logic addr_ok;

    assign strap = '{load: offset_load_select, sel1: default_offset_sel1,
                     sel0: default_offset_sel0};

    fpo_default_offset u_default (
        .strap(strap),
        .depth(fpo_depth_t'(depth_select)),
        .offset(default_ofs)
    );

    // ================================================================
    // settings caught during master reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_q <= '0;
        end else if (!master_reset_n) begin
            cfg_q.serial_mode <= offset_load_select;
            cfg_q.sync_flags <= flag_timing_select;
            cfg_q.depth <= fpo_depth_t'(depth_select);
        end
    end

    // ================================================================
    // ahb-lite address and data phase
    assign addr_ok = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_addr_q <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            dp_wr_q <= addr_ok && hwrite;
            dp_addr_q <= haddr;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            unique case (haddr)
                `FPO_REG_STATUS: hrdata <= {30'h0000_0000, status_q};
                `FPO_REG_MASK: hrdata <= {30'h0000_0000, mask_q};
                `FPO_REG_SERIAL: hrdata <= {26'h000_0000, ser_cnt_q};
                `FPO_REG_CONFIG: hrdata <= {15'h0000, count_q} << `FPO_CFG_COUNT_LSB
                                           | {25'h000_0000, cfg_q.depth, 4'h0}
                                           | {30'h0000_0000, cfg_q.sync_flags,
                                              cfg_q.serial_mode};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ================================================================
    // offset registers: defaults at master reset, then serial or parallel load
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            empty_ofs_q <= `FPO_OFS_RST;
            full_ofs_q <= `FPO_OFS_RST;
            ser_shift_q <= 32'h0000_0000;
            ser_cnt_q <= 6'h00;
        end else if (!master_reset_n) begin
            empty_ofs_q <= default_ofs;
            full_ofs_q <= default_ofs;
            ser_shift_q <= 32'h0000_0000;
            ser_cnt_q <= 6'h00;
        end else if (dp_wr_q) begin
            if (!cfg_q.serial_mode && dp_addr_q == `FPO_REG_EMPTY_OFS) begin
                empty_ofs_q <= hwdata[15:0];
            end
            if (!cfg_q.serial_mode && dp_addr_q == `FPO_REG_FULL_OFS) begin
                full_ofs_q <= hwdata[15:0];
            end
            if (cfg_q.serial_mode && dp_addr_q == `FPO_REG_SERIAL) begin
                if (ser_cnt_q == `FPO_SER_BITS - 6'h01) begin
                    empty_ofs_q <= ser_shift_q[30:15];
                    full_ofs_q <= {ser_shift_q[14:0], hwdata[0]};
                    ser_cnt_q <= 6'h00;
                end else begin
                    ser_cnt_q <= ser_cnt_q + 6'h01;
                end
                ser_shift_q <= {ser_shift_q[30:0], hwdata[0]};
            end
        end
    end

    // ================================================================
    // word count
    assign do_wr = wclk_rise && write_en && count_q != depth_words(cfg_q.depth);
    assign do_rd = rclk_rise && read_en && count_q != 17'h0_0000;
    assign count_d = count_q + 17'(do_wr) - 17'(do_rd);
    assign ae_next = ae_cond(count_d, empty_ofs_q);
    assign af_next = af_cond(count_d, full_ofs_q, cfg_q.depth);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_q <= 17'h0_0000;
        end else if (!master_reset_n || !partial_reset_n) begin
            count_q <= 17'h0_0000;
        end else begin
            count_q <= count_d;
        end
    end

    // ================================================================
    // almost-empty flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            almost_empty_flag_n <= 1'b0;
        end else if (!master_reset_n || !partial_reset_n) begin
            almost_empty_flag_n <= 1'b0;
        end else if (cfg_q.sync_flags) begin
            if (rclk_rise) begin
                almost_empty_flag_n <= !ae_next;
            end
        end else if (rclk_rise && ae_next) begin
            almost_empty_flag_n <= 1'b0;
        end else if (wclk_rise && !ae_next) begin
            almost_empty_flag_n <= 1'b1;
        end
    end

    // ================================================================
    // almost-full flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            almost_full_flag_n <= 1'b1;
        end else if (!master_reset_n || !partial_reset_n) begin
            almost_full_flag_n <= 1'b1;
        end else if (cfg_q.sync_flags) begin
            if (wclk_rise) begin
                almost_full_flag_n <= !af_next;
            end
        end else if (wclk_rise && af_next) begin
            almost_full_flag_n <= 1'b0;
        end else if (rclk_rise && !af_next) begin
            almost_full_flag_n <= 1'b1;
        end
    end

    // ================================================================
    // offset readback on the parallel data output
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parallel_data_out <= 72'h00_0000_0000_0000_0000;
            rb_sel_q <= 1'b0;
        end else if (!master_reset_n) begin
            parallel_data_out <= 72'h00_0000_0000_0000_0000;
            rb_sel_q <= 1'b0;
        end else if (rclk_rise && offset_read) begin
            parallel_data_out <= {56'h00_0000_0000_0000,
                                  rb_sel_q ? full_ofs_q : empty_ofs_q};
            rb_sel_q <= !rb_sel_q;
        end
    end

    // ================================================================
    // interrupts: flag assertion events, cleared by status read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= 2'h0;
        end else begin
            status_q <= (status_q & ~({2{addr_ok && !hwrite && haddr == `FPO_REG_STATUS}}))
                        | {almost_full_flag_n && !almost_full_flag_n_nx(),
                           almost_empty_flag_n && !almost_empty_flag_n_nx()};
        end
    end

    function automatic logic almost_full_flag_n_nx();
        if (!master_reset_n || !partial_reset_n) begin
            almost_full_flag_n_nx = 1'b1;
        end else if (cfg_q.sync_flags) begin
            almost_full_flag_n_nx = wclk_rise ? !af_next : almost_full_flag_n;
        end else if (wclk_rise && af_next) begin
            almost_full_flag_n_nx = 1'b0;
        end else begin
            almost_full_flag_n_nx = almost_full_flag_n;
        end
    endfunction

    function automatic logic almost_empty_flag_n_nx();
        if (!master_reset_n || !partial_reset_n) begin
            almost_empty_flag_n_nx = 1'b0;
        end else if (cfg_q.sync_flags) begin
            almost_empty_flag_n_nx = rclk_rise ? !ae_next : almost_empty_flag_n;
        end else if (rclk_rise && ae_next) begin
            almost_empty_flag_n_nx = 1'b0;
        end else begin
            almost_empty_flag_n_nx = almost_empty_flag_n;
        end
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_q <= `FPO_MASK_RST;
        end else if (dp_wr_q && dp_addr_q == `FPO_REG_MASK) begin
            mask_q <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end
endmodule // fpo_top

// ===== bench/fpo_top_props.sv
// assertion checker for the flag offset block ports
module fpo_top_props (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // fifo side
    input wire logic master_reset_n,
    input wire logic partial_reset_n,
    input wire logic flag_timing_select,
    input wire logic wclk_rise,
    input wire logic rclk_rise,
    input wire logic offset_read,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic [71:0] parallel_data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sync_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ====
    // latched flag timing and sequences
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_q <= 1'b0;
        end else if (!master_reset_n) begin
            sync_q <= flag_timing_select;
        end
    end
    sequence rd_req;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence calm;
        $past(hresetn) && $past(master_reset_n) && $past(partial_reset_n);
    endsequence
    sequence sync_on;
        calm ##0 sync_q;
    endsequence
    sequence async_on;
        calm ##0 !sync_q;
    endsequence
    // ====
    // properties
    AST_BUS_OKAY: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus slave not ready or not okay");
    AST_RD_ZERO: assert property (
        rd_req ##0 (haddr == 8'h08 || haddr == 8'h0c || haddr >= 8'h18) |=> hrdata == 32'h0)
        else $error("offset or unmapped read not zero");
    AST_PDO_HIGH: assert property (parallel_data_out[71:16] == 56'h0)
        else $error("readback upper bits not zero");
    AST_PDO_CAUSE: assert property (
        calm ##0 !$stable(parallel_data_out) |-> $past(rclk_rise && offset_read))
        else $error("readback moved without offset read");
    AST_SYNC_FULL: assert property (
        sync_on ##0 !$stable(almost_full_flag_n) |-> $past(wclk_rise))
        else $error("sync full flag moved off write edge");
    AST_SYNC_EMPTY: assert property (
        sync_on ##0 !$stable(almost_empty_flag_n) |-> $past(rclk_rise))
        else $error("sync empty flag moved off read edge");
    AST_FULL_FALL: assert property (
        async_on ##0 $fell(almost_full_flag_n) |-> $past(wclk_rise))
        else $error("async full flag fell off write edge");
    AST_FULL_RISE: assert property (
        async_on ##0 $rose(almost_full_flag_n) |-> $past(rclk_rise))
        else $error("async full flag rose off read edge");
    AST_EMPTY_FALL: assert property (
        async_on ##0 $fell(almost_empty_flag_n) |-> $past(rclk_rise))
        else $error("async empty flag fell off read edge");
    AST_EMPTY_RISE: assert property (
        async_on ##0 $rose(almost_empty_flag_n) |-> $past(wclk_rise))
        else $error("async empty flag rose off write edge");
    AST_MASTER_CLEAR: assert property (
        !master_reset_n |=> !almost_empty_flag_n && almost_full_flag_n)
        else $error("flags not cleared by master reset");
endmodule // fpo_top_props

// ===== bench/fpo_host.sv
// host-side model: fifo edges, resets and straps
module fpo_host (
    // clock
    input wire logic hclk,
    // resets and straps
    output logic master_reset_n,
    output logic partial_reset_n,
    output logic offset_load_select,
    output logic default_offset_sel1,
    output logic default_offset_sel0,
    output logic flag_timing_select,
    output logic [2:0] depth_select,
    // write and read edges
    output logic wclk_rise,
    output logic write_en,
    output logic rclk_rise,
    output logic read_en,
    output logic offset_read
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {master_reset_n, offset_load_select, default_offset_sel1, default_offset_sel0,
            flag_timing_select, depth_select, wclk_rise, write_en, rclk_rise, read_en,
            offset_read} <= 13'h0;
        partial_reset_n <= 1'b1;
    end
    // ====
    // straps held stable across the whole master reset
    task automatic master_rst(input logic load_sel, input logic s1, input logic s0,
                              input logic timing_sel, input logic [2:0] d);
        offset_load_select <= load_sel;
        default_offset_sel1 <= s1;
        default_offset_sel0 <= s0;
        flag_timing_select <= timing_sel;
        depth_select <= d;
        master_reset_n <= 1'b0;
        repeat (2) @(posedge hclk);
        master_reset_n <= 1'b1;
        @(posedge hclk);
    endtask
    task automatic prst();
        partial_reset_n <= 1'b0;
        @(posedge hclk);
        partial_reset_n <= 1'b1;
        @(posedge hclk);
    endtask
    // one-cycle edge pulses, gap sets how slowly the host paces them
    task automatic wedge(input logic en, input int gap);
        wclk_rise <= 1'b1;
        write_en <= en;
        @(posedge hclk);
        wclk_rise <= 1'b0;
        write_en <= 1'b0;
        repeat (gap) @(posedge hclk);
    endtask
    task automatic redge(input logic en, input logic ofs, input int gap);
        rclk_rise <= 1'b1;
        read_en <= en;
        offset_read <= ofs;
        @(posedge hclk);
        rclk_rise <= 1'b0;
        read_en <= 1'b0;
        offset_read <= 1'b0;
        repeat (gap) @(posedge hclk);
    endtask
endmodule // fpo_host

// ===== bench/tb.sv
// self-checking testbench for the flag offset block
`include "fpo_consts.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 1'b0;
    logic hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, depth_select;
    logic [31:0] hwdata, hrdata, rd;
    logic master_reset_n, partial_reset_n, offset_load_select, default_offset_sel1;
    logic default_offset_sel0, flag_timing_select, wclk_rise, write_en;
    logic rclk_rise, read_en, offset_read, almost_empty_flag_n, almost_full_flag_n;
    logic [71:0] parallel_data_out;
    wire [1:0] flg = {almost_empty_flag_n, almost_full_flag_n};
    int err_total = 0;
    int n_tests = 0;
    localparam logic [15:0] def_ofs [3][8] = '{
        '{16'h007f, 16'h00ff, 16'h01ff, 16'h003f, 16'h001f, 16'h0007, 16'h000f, 16'h0003},
        '{16'h007f, 16'h00ff, 16'h01ff, 16'h003f, 16'h03ff, 16'h000f, 16'h001f, 16'h0007},
        '{16'h007f, 16'h1fff, 16'h3fff, 16'h0fff, 16'h03ff, 16'h01ff, 16'h07ff, 16'h00ff}};
    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    fpo_top i_fpo_top (.*);
    fpo_host i_fpo_host (.*);
    // ====
    // bus, compare and report tasks
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rb(input logic [15:0] e, input logic [15:0] f);
        i_fpo_host.redge(1'b0, 1'b1, 1);
        chk(parallel_data_out, {56'h0, e});
        i_fpo_host.redge(1'b0, 1'b1, 1);
        chk(parallel_data_out, {56'h0, f});
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        final_report;
    end
    // ====
    // tests
    initial begin
        int g;
        logic [31:0] sv;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} <= 45'h0;
        hsize <= 3'h2;
        sv = 32'h0015_0102;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int d = 0; d < 8; d++) begin
            g = d < 2 ? 0 : (d < 6 ? 1 : 2);
            for (int c = 0; c < 8; c++) begin
                i_fpo_host.master_rst(c[2], c[1], c[0], c[0], d[2:0]);
                bus(1'b0, `FPO_REG_CONFIG, 32'h0);
                chk(rd, {25'h0, d[2:0], 2'h0, c[0], c[2]});
                rb(def_ofs[g][c], def_ofs[g][c]);
            end
        end
        i_fpo_host.master_rst(1'b0, 1'b1, 1'b0, 1'b1, 3'h0);
        bus(1'b1, `FPO_REG_EMPTY_OFS, 32'h0000_0003);
        bus(1'b1, `FPO_REG_FULL_OFS, 32'h0000_01f4);
        bus(1'b0, `FPO_REG_EMPTY_OFS, 32'h0);
        chk(rd, 32'h0);
        rb(16'h0003, 16'h01f4);
        repeat (3) i_fpo_host.wedge(1'b1, 1);
        i_fpo_host.redge(1'b0, 1'b0, 1);
        chk(flg, 2'h1);
        i_fpo_host.wedge(1'b1, 1);
        chk(flg, 2'h1);
        i_fpo_host.redge(1'b0, 1'b0, 1);
        chk(flg, 2'h3);
        repeat (7) i_fpo_host.wedge(1'b1, 1);
        chk(flg, 2'h3);
        i_fpo_host.wedge(1'b1, 1);
        chk(flg, 2'h2);
        chk(irq, 1'b0);
        bus(1'b1, `FPO_REG_MASK, 32'h0000_0002);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b1);
        bus(1'b0, `FPO_REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0002);
        repeat (3) @(posedge hclk);
        chk(irq, 1'b0);
        i_fpo_host.redge(1'b1, 1'b0, 1);
        chk(flg, 2'h2);
        i_fpo_host.wedge(1'b0, 1);
        chk(flg, 2'h3);
        i_fpo_host.master_rst(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
        bus(1'b1, `FPO_REG_EMPTY_OFS, 32'h0000_0001);
        bus(1'b1, `FPO_REG_FULL_OFS, 32'h0000_01fe);
        i_fpo_host.wedge(1'b1, 2);
        chk(flg, 2'h1);
        i_fpo_host.wedge(1'b1, 2);
        chk(flg, 2'h2);
        i_fpo_host.redge(1'b1, 1'b0, 2);
        chk(flg, 2'h1);
        bus(1'b0, `FPO_REG_STATUS, 32'h0);
        chk(rd, 32'h0000_0003);
        i_fpo_host.master_rst(1'b1, 1'b1, 1'b1, 1'b1, 3'h0);
        bus(1'b1, `FPO_REG_EMPTY_OFS, 32'h0000_0009);
        rb(16'h0003, 16'h0003);
        for (int i = 31; i >= 0; i--) bus(1'b1, `FPO_REG_SERIAL, {31'h0, sv[i]});
        rb(16'h0015, 16'h0102);
        i_fpo_host.prst();
        bus(1'b0, `FPO_REG_CONFIG, 32'h0);
        chk(rd, 32'h0000_0003);
        rb(16'h0015, 16'h0102);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        final_report;
    end
endmodule // tb
bind fpo_top fpo_top_props i_props (.*);
